/* File: common/ppc_pkg.sv */
// Constants shared by the parallel port pin control block.
package ppc_pkg;
   // Width of the port in pins.
   localparam int unsigned PPC_WIDTH = 8;
   // Width of the byte offset seen on the register port.
   localparam int unsigned PPC_ADDR_W = 8;
   // Byte offset of the read/write port pin data register.
   localparam logic [7:0] PPC_OFS_DATA = 8'h10;
   // Byte offset of the write-only port pin direction register.
   localparam logic [7:0] PPC_OFS_DIR = 8'h11;
   // Byte offset of the write-only port pin function select register.
   localparam logic [7:0] PPC_OFS_FSEL = 8'h12;
   // Function select after reset: every pin in general-purpose mode.
   localparam logic [7:0] PPC_RST_FSEL = 8'h00;
   // Direction after reset: every pin an input.
   localparam logic [7:0] PPC_RST_DIR = 8'hff;
   // Output data latch after reset.
   localparam logic [7:0] PPC_RST_DATA = 8'h00;
   // Value returned for a read of an unmapped or write-only offset.
   localparam logic [7:0] PPC_RD_NONE = 8'h00;
   // Number of flip-flops in a pin synchroniser.
   localparam int unsigned PPC_SYNC_STAGES = 2;
endpackage

/* File: design/ppc_pin_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser, one chain per pin.
module ppc_pin_sync
#(
   parameter int unsigned WIDTH = 8
)
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   // Each bit gets its own first and second stage; only the second is visible.
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++)
      begin : g_bit
         logic meta; // First stage, read only by the second stage.
         logic stable; // Second stage, safe for logic to read.
         // The two stages are plain flip-flops cleared by the synchronous reset.
         always_ff @(posedge i_core_clk)
         begin
            if (i_srst)
            begin
               meta <= 1'b0;
               stable <= 1'b0;
            end
            else
            begin
               meta <= i_async[gi];
               stable <= meta;
            end
         end
         assign o_sync[gi] = stable;
      end
   endgenerate
endmodule

/* File: design/ppc_port.sv */
`timescale 1ns/1ps
// Operation
// - Function bit: 0 general I/O, 1 alternate.
// - Direction bit: 0 output, 1 input.
// - Direction ignored for alternate-function pins.
// - Data write changes only I/O output pins.
// - Port read returns each pin's I/O value.
// - Data register at 0x10 is read/write.
// - Direction at 0x11 takes whole-byte writes.
// - Function value 0x09 hands pins 0,3 over.
// - All outputs: data bit 3 drives pin 3.
module ppc_port
(
   input wire logic i_core_clk, // Processor clock.
   input wire logic i_srst, // Synchronous reset, active high.
   input wire logic [ppc_pkg::PPC_ADDR_W-1:0] i_addr, // Byte offset of the access.
   input wire logic i_wr, // Write strobe, one cycle per byte written.
   input wire logic i_rd, // Read strobe, one cycle per byte read.
   input wire logic [ppc_pkg::PPC_WIDTH-1:0] i_wdata, // Write data byte.
   output logic [ppc_pkg::PPC_WIDTH-1:0] o_rdata, // Read data, valid the cycle after i_rd.
   input wire logic [ppc_pkg::PPC_WIDTH-1:0] i_pin_in, // Level seen on each pin.
   output logic [ppc_pkg::PPC_WIDTH-1:0] o_pin_out, // Level driven on each pin.
   output logic [ppc_pkg::PPC_WIDTH-1:0] o_pin_oe, // High while the pin is driven.
   input wire logic [ppc_pkg::PPC_WIDTH-1:0] i_alt_out, // Alternate function drive level.
   input wire logic [ppc_pkg::PPC_WIDTH-1:0] i_alt_oe, // Alternate function drive enable.
   output logic [ppc_pkg::PPC_WIDTH-1:0] o_alt_in, // Synchronised pins for alternate use.
   output logic [ppc_pkg::PPC_WIDTH-1:0] o_alt_sel // Pins handed to their alternate function.
);
   import ppc_pkg::*;

   // Short name for the port width; every per-pin vector below uses it.
   localparam int unsigned W = PPC_WIDTH;

   // Register state, the next values computed for it and the decoded strobes.
   logic [W-1:0] fsel; // Function select register, 1 means alternate function.
   logic [W-1:0] dir; // Direction register, 1 means input.
   logic [W-1:0] data; // Output data latch.
   logic [W-1:0] pin_sync; // Pin levels after the synchroniser.
   logic [W-1:0] next_fsel; // Next function select.
   logic [W-1:0] next_dir; // Next direction.
   logic [W-1:0] next_data; // Next output data latch.
   logic [W-1:0] next_rdata; // Next read data.
   logic [W-1:0] next_pin_out; // Next pin drive level.
   logic [W-1:0] next_pin_oe; // Next pin drive enable.
   logic [W-1:0] io_out; // Pins that are general I/O and outputs now.
   logic [W-1:0] next_io_out; // Pins that are general I/O and outputs after this edge.
   logic [W-1:0] port_value; // Current I/O value of each pin.
   logic wr_data; // Write to the data register.
   logic wr_dir; // Write to the direction register.
   logic wr_fsel; // Write to the function select register.

   // External pins cross into the clock domain before any logic sees them.
   ppc_pin_sync #(.WIDTH(W)) u_sync
   (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_async(i_pin_in),
      .o_sync(pin_sync)
   );

   // Address decode of the three byte registers.
   assign wr_data = i_wr && (i_addr == PPC_OFS_DATA);
   assign wr_dir = i_wr && (i_addr == PPC_OFS_DIR);
   assign wr_fsel = i_wr && (i_addr == PPC_OFS_FSEL);

   // Only general-purpose pins set as outputs take the data latch.
   assign io_out = ~fsel & ~dir;
   assign next_io_out = ~next_fsel & ~next_dir;

   // An output pin reads back its latch, any other pin its synchronised level.
   assign port_value = (data & io_out) | (pin_sync & ~io_out);

   // Next values of the configuration, latch, pins and read data.
   always_comb
   begin
      next_fsel = fsel;
      next_dir = dir;
      next_data = data;
      next_rdata = PPC_RD_NONE;
      if (wr_fsel)
      begin
         // Each bit picks general I/O or the alternate function.
         next_fsel = i_wdata;
      end
      if (wr_dir)
      begin
         // The whole byte replaces the direction register.
         next_dir = i_wdata;
      end
      if (wr_data)
      begin
         // Bits of pins that are not I/O outputs keep their latched value.
         next_data = (i_wdata & io_out) | (data & ~io_out);
      end
      if (i_rd && (i_addr == PPC_OFS_DATA))
      begin
         // The data register is the only readable one; the others read as zero.
         next_rdata = port_value;
      end
      // Alternate pins follow their function; the others follow latch and direction.
      next_pin_out = (next_fsel & i_alt_out) | (~next_fsel & next_data);
      next_pin_oe = (next_fsel & i_alt_oe) | next_io_out;
   end

   // Registers of the block; reset leaves every pin a general-purpose input.
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         fsel <= PPC_RST_FSEL;
         dir <= PPC_RST_DIR;
         data <= PPC_RST_DATA;
         o_rdata <= PPC_RD_NONE;
         o_pin_out <= PPC_RST_DATA;
         o_pin_oe <= '0;
         o_alt_in <= '0;
         o_alt_sel <= PPC_RST_FSEL;
      end
      else
      begin
         fsel <= next_fsel;
         dir <= next_dir;
         data <= next_data;
         o_rdata <= next_rdata;
         o_pin_out <= next_pin_out;
         o_pin_oe <= next_pin_oe;
         o_alt_in <= pin_sync;
         o_alt_sel <= next_fsel;
      end
   end

   // Checks of the block against its own registers.
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_srst);

   // A direction write followed by the resulting drive enables.
   sequence s_dir_write;
      wr_dir ##1 1'b1;
   endsequence

   // Direction governs the drive enable of general-purpose pins only.
   io_dir_oe_a: assert property ((o_pin_oe & ~fsel) == (~dir & ~fsel))
      else $error("general pin enable does not follow direction");

   // Alternate pins take their enable from the alternate function only.
   alt_pin_oe_a: assert property ((o_pin_oe & fsel) == ($past(i_alt_oe) & fsel))
      else $error("alternate pin enable not from its function");

   // A data write leaves every pin that is not an I/O output unchanged.
   data_keep_a: assert property (wr_data |=> ((data ^ $past(data)) & ~$past(io_out)) == '0)
      else $error("data write changed a non output pin");

   // A data write lands on the I/O output pins and reaches them one edge later.
   data_take_a: assert property (wr_data |=> ((o_pin_out & $past(io_out)) ==
      ($past(i_wdata) & $past(io_out))))
      else $error("data write did not reach output pins");

   // A read of the data register returns the port value of the cycle it was asked.
   data_read_a: assert property (i_rd && (i_addr == PPC_OFS_DATA) |=>
      o_rdata == $past(port_value))
      else $error("port read returned wrong value");

   // A direction write takes the whole byte and its enables appear together.
   dir_write_a: assert property (s_dir_write |-> dir == $past(i_wdata) &&
      ((o_pin_oe & ~fsel) == (~$past(i_wdata) & ~fsel)))
      else $error("direction byte not taken");

   // With function 0x09 the six other pins still obey direction.
   dma_cfg_a: assert property (fsel == 8'h09 |-> (o_pin_oe & 8'hf6) == (~dir & 8'hf6))
      else $error("pins outside the alternate set not general I/O");

   // Leaving reset every pin is a general-purpose input and undriven.
   reset_state_a: assert property ($past(i_srst) |-> fsel == PPC_RST_FSEL &&
      dir == PPC_RST_DIR && o_pin_oe == '0)
      else $error("reset state is not all general inputs");

   // Reads of any other offset answer zero.
   unmapped_rd_a: assert property (i_rd && (i_addr != PPC_OFS_DATA) |=> o_rdata == PPC_RD_NONE)
      else $error("unmapped read not zero");

   // With no read strobe the read data fall back to zero in the next cycle.
   rd_idle_a: assert property (!i_rd |=> o_rdata == PPC_RD_NONE)
      else $error("read data did not return to zero");

   // A read strobe at the data offset and the edge that answers it.
   sequence s_data_read;
      i_rd && (i_addr == PPC_OFS_DATA) ##1 1'b1;
   endsequence

   // Output pins read back their latch, not the level on the pin.
   latch_readback_a: assert property (s_data_read |->
      (o_rdata & $past(io_out)) == ($past(data) & $past(io_out)))
      else $error("output pin read did not return latch");

   // Input and alternate pins read back their synchronised level.
   pin_readback_a: assert property (s_data_read |->
      (o_rdata & ~$past(io_out)) == ($past(pin_sync) & ~$past(io_out)))
      else $error("input pin read did not return pin level");

   // The latch moves only on a write to the data register.
   data_hold_a: assert property (!wr_data |=> data == $past(data))
      else $error("data latch changed without a data write");

   // A direction write never touches the enables of alternate pins.
   alt_dir_free_a: assert property (wr_dir |=>
      (o_pin_oe & fsel) == ($past(i_alt_oe) & fsel))
      else $error("direction write changed an alternate pin enable");

   // The function select copy seen by the alternate functions matches the register.
   alt_sel_copy_a: assert property (o_alt_sel == fsel)
      else $error("alternate select copy differs from register");

   // With function 0x09 pins 0 and 3 drive what their alternate function asks.
   dma_pins_a: assert property (fsel == 8'h09 |-> o_alt_sel == 8'h09 &&
      (o_pin_out & 8'h09) == ($past(i_alt_out) & 8'h09))
      else $error("alternate pins 0 and 3 not under their function");

   // With every pin a general output, each data bit drives its own pin.
   all_out_drive_a: assert property (fsel == '0 && dir == '0 |->
      o_pin_out == data && o_pin_oe == 8'hff)
      else $error("all-output port does not drive its latch");
endmodule

/* File: bench/ppc_board.sv */
`timescale 1ns/1ps
// Board peripherals seen from the port pins.
module ppc_board
(
   input wire logic [7:0] i_oe, // Drive enables from the port.
   input wire logic [7:0] i_drv, // Levels driven by the port.
   input wire logic [7:0] i_ext, // Levels the peripherals put on undriven pins.
   output logic [7:0] o_level // Resolved level on each pin.
);
   // A pin follows the port while it is driven, otherwise the peripheral.
   always_comb
   begin
      o_level = (i_oe & i_drv) | (~i_oe & i_ext);
   end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import ppc_pkg::*;
   logic i_core_clk = 1'b0; // Core clock.
   logic i_srst = 1'b1; // Reset, held at start.
   logic i_wr = 1'b0, i_rd = 1'b0; // Access strobes.
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_alt_out = 8'h00, i_alt_oe = 8'h00;
   logic [7:0] ext = 8'h00; // Peripheral levels on undriven pins.
   logic [7:0] o_rdata, o_pin_out, o_pin_oe, i_pin_in, o_alt_in, o_alt_sel;
   logic [7:0] fsel, dir, lat, seen; // Shadow copies kept by the bench.
   logic [7:0] ofs [4] = '{8'h10, 8'h11, 8'h12, 8'h20}; // Offsets tried at random.
   int n_mismatch = 0, total_checks = 0;
   // Pins in general mode set as outputs.
   wire [7:0] io = ~fsel & ~dir;
   // Expected drive enable, drive level and resolved pin level.
   wire [7:0] eoe = (fsel & i_alt_oe) | io;
   wire [7:0] eout = (fsel & i_alt_out) | (~fsel & lat);
   wire [7:0] lv = (eoe & eout) | (~eoe & ext);

   always #5 i_core_clk = ~i_core_clk;

   ppc_port dut (.i_core_clk, .i_srst, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata,
      .i_pin_in, .o_pin_out, .o_pin_oe, .i_alt_out, .i_alt_oe, .o_alt_in, .o_alt_sel);
   ppc_board board (.i_oe(o_pin_oe), .i_drv(o_pin_out), .i_ext(ext), .o_level(i_pin_in));

   // Compares one value and counts it.
   task chk(input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // Writes one byte and updates the shadow copies.
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_core_clk);
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      @(negedge i_core_clk);
      i_wr = 1'b0;
      case (a)
         PPC_OFS_DATA: lat = (lat & ~io) | (d & io);
         PPC_OFS_DIR: dir = d;
         PPC_OFS_FSEL: fsel = d;
         default: ;
      endcase
   endtask

   // Reads one byte and compares it in the cycle after the strobe.
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge i_core_clk);
      i_addr = a;
      i_rd = 1'b1;
      @(negedge i_core_clk);
      i_rd = 1'b0;
      seen = o_rdata;
      chk(o_rdata, e);
   endtask

   // New pin levels, one write, settling time, then a full port check.
   task step(input logic [7:0] a, input logic [7:0] d);
      ext = 8'($urandom);
      i_alt_out = 8'($urandom);
      i_alt_oe = 8'($urandom);
      wr(a, d);
      repeat (4) @(negedge i_core_clk);
      chk(o_pin_oe, eoe);
      chk(o_pin_out & eoe, eout & eoe);
      chk(o_alt_sel, fsel);
      chk(o_alt_in, lv);
      chk(o_rdata, PPC_RD_NONE);
      rd(PPC_OFS_DATA, (io & lat) | (~io & lv));
   endtask

   // Prints the counts and the verdict, then stops.
   task print_verdict;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Cuts a hang short well after the expected run length.
   initial
   begin
      #100000;
      n_mismatch++;
      print_verdict();
   end

   initial
   begin
      void'($urandom(32'h6b0c));
      fsel = PPC_RST_FSEL;
      dir = PPC_RST_DIR;
      lat = PPC_RST_DATA;
      repeat (16) @(negedge i_core_clk);
      i_srst = 1'b0;
      step(8'h20, 8'h5a);
      step(8'h11, dir & 8'hf0);
      step(8'h10, 8'ha5);
      step(8'h11, 8'h00);
      step(8'h10, 8'h08);
      // Read, mask and write back to clear pin 3 alone.
      rd(PPC_OFS_DATA, lat);
      wr(PPC_OFS_DATA, seen & 8'hf7);
      rd(PPC_OFS_DATA, 8'h00);
      step(8'h12, 8'h09);
      step(8'h10, 8'hff);
      // Write-only and unmapped offsets read back as zero.
      rd(PPC_OFS_DIR, PPC_RD_NONE);
      rd(PPC_OFS_FSEL, PPC_RD_NONE);
      rd(8'h20, PPC_RD_NONE);
      // A reset in mid-run returns every pin to a general-purpose input.
      @(negedge i_core_clk);
      i_srst = 1'b1;
      repeat (3) @(negedge i_core_clk);
      i_srst = 1'b0;
      fsel = PPC_RST_FSEL;
      dir = PPC_RST_DIR;
      lat = PPC_RST_DATA;
      step(8'h20, 8'h00);
      repeat (40) step(ofs[$urandom_range(3)], 8'($urandom));
      print_verdict();
   end
endmodule
